/* File: pkg/vt_regs.svh */
// register map, control and status bit positions, reset values and
// cycle counts of the vector transform engine.
// assumes a 100 mhz ref_clk; index = word number on the apb bus.
`ifndef VT_REGS_SVH
`define VT_REGS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define REG_REV_ANGLE 4'h0
`define REG_IN1 4'h1
`define REG_IN2 4'h2
`define REG_IN3 4'h3
`define REG_FWD_ANGLE 4'h4
`define REG_PWM_LAST 4'ha
`define REG_RES0 4'h0
`define REG_RES3 4'h3
`define REG_ADC_FIRST 4'h5
`define REG_ADC_LAST 4'h8
`define REG_CTRL 4'hd
`define REG_STAT 4'he

// ****************************************
// field positions and reset values
// ****************************************
`define CTRL_CLKDIV 5
`define CTRL_TR_IE 6
`define CTRL_ADC_IE 7
`define CTRL_LEVEL 8
`define CTRL_THREE 10
`define STAT_ADC 0
`define STAT_TR 1
`define STAT_ANY 11
`define CTRL_RESET 12'h000

// ****************************************
// timing counts and fixed point constants (q14)
// ****************************************
`define REV_CYCLES 6'h25
`define FWD_CYCLES 6'h28
`define CORDIC_STEPS 4'he
`define INV_GAIN 16'sh26dd
`define INV_SQRT3 16'sh24f3
`define HALF_SQRT3 16'sh376d
`define HALF_ONE 16'sh2000
`define FULL_ONE 16'sh4000

`endif

/* File: pkg/vt_pkg.sv */
// types shared by the vector transform engine.
// assumes nothing of its surroundings.
package vt_pkg;

  // engine sequence
  typedef enum logic [1:0] {ST_IDLE, ST_ROTATE, ST_COMPUTE, ST_WAIT} engine_state_t;

  // which transform runs
  typedef enum logic {DIR_REV, DIR_FWD} dir_t;

  // all state of the block
  typedef struct packed {
    logic [11:0] ctrl;
    logic [2:0] stat;
    logic [11:0] in1;
    logic [11:0] in2;
    logic [11:0] in3;
    logic [11:0] res0;
    logic [11:0] res1;
    logic [11:0] res2;
    logic [11:0] res3;
    engine_state_t st;
    dir_t dir;
    logic [5:0] cnt;
    logic [15:0] cx;
    logic [15:0] cy;
    logic [16:0] cz;
    logic flip;
    logic tick_ph;
    logic pulse;
    logic [11:0] rdata;
  } vt_state_t;

endpackage : vt_pkg

/* File: design/vector_transform_with_interrupts.sv */
// vector transform engine (clarke/park both ways) with interrupt logic.
// assumes an apb master on ref_clk, adc_eoc as a one-cycle pulse from
// logic on the same clock, and a board pull-up on the request wire.
//
// Behaviour
// - quadrature clarke: (phase3 minus phase2)/root3
// - two-phase mode: phase1 is negated sum
// - reverse rotation by angle gives direct, quadrature
// - sine and cosine made internally from angle
// - forward transform completes 40 system cycles later
// - forward rotation feeds two-to-three conversion
// - three phase voltages from alpha and beta
// - two sources: adc end, transform end
// - control bits 7, 6 enable; reset clears
// - enabled event sets status 11 plus source
// - status read clears bits 11,1,0
// - request pin is open drain, active low
// - edge mode: low until the next system tick
// - level mode: low until status read
// - control bit 8 picks edge or level
// - twelve-bit register data with the host
// - reverse angle write starts, done 37 later
// - control bit 10 clear: two-phase mode
// - angles unsigned turn fractions, rest signed
// - write captured at the write strobe edge
`timescale 1ns/1ps
`default_nettype none
`include "vt_regs.svh"

module vector_transform_with_interrupts (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_eoc,
  input wire logic irq_n_in,
  output logic irq_n_out,
  output logic irq_n_oe
);

  // ****************************************
  // state and helpers
  // ****************************************
  vt_pkg::vt_state_t r; // registered state
  vt_pkg::vt_state_t next_r; // next state
  logic [3:0] idx; // register index
  logic aligned; // word-aligned address
  logic wr_ok; // write to a mapped register
  logic rd_ok; // read of a mapped register
  logic wr_acc; // write completes this edge
  logic rd_acc; // read completes this edge
  logic tick; // system clock enable
  logic [11:0] rd_mux; // read data before capture
  logic signed [15:0] cos_v; // cosine, q14
  logic signed [15:0] sin_v; // sine, q14
  logic [11:0] ix; // clarke alpha current
  logic [11:0] iy; // clarke beta current
  logic [11:0] vx; // forward alpha voltage
  logic [11:0] vy; // forward beta voltage
  logic ev_adc; // enabled adc event
  logic ev_tr; // enabled transform event
  logic tr_done; // transform finishes this edge
  logic drive_low; // pull the request wire low

  // sign-extend a 12-bit register to 14 bits
  function automatic logic signed [13:0] ext(input logic [11:0] x);
    ext = {{2{x[11]}}, x};
  endfunction : ext

  // signed product, wide enough for any pair
  function automatic logic signed [30:0] mul(input logic signed [13:0] a,
                                             input logic signed [15:0] b);
    mul = 31'(a) * 31'(b);
  endfunction : mul

  // drop the q14 fraction and clamp to 12-bit twos complement
  function automatic logic [11:0] sat(input logic signed [30:0] v);
    logic signed [30:0] t;
    t = v >>> 14;
    if (t > 31'sh7ff) begin
      sat = 12'h7ff;
    end else if (t < -31'sh800) begin
      sat = 12'h800;
    end else begin
      sat = t[11:0];
    end
  endfunction : sat

  // arctangent of 2^-i in 2^-16 turn units
  function automatic logic signed [16:0] atan(input logic [3:0] i);
    case (i)
      4'h0: atan = 17'sh2000;
      4'h1: atan = 17'sh12e4;
      4'h2: atan = 17'sh09fb;
      4'h3: atan = 17'sh0511;
      4'h4: atan = 17'sh028b;
      4'h5: atan = 17'sh0146;
      4'h6: atan = 17'sh00a3;
      4'h7: atan = 17'sh0051;
      4'h8: atan = 17'sh0029;
      4'h9: atan = 17'sh0014;
      4'ha: atan = 17'sh000a;
      4'hb: atan = 17'sh0005;
      4'hc: atan = 17'sh0003;
      default: atan = 17'sh0001;
    endcase
  endfunction : atan

  // ****************************************
  // bus decode
  // ****************************************
  // pready follows the clock enable so a frozen block stalls the master
  assign idx = paddr[5:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wr_ok = aligned && (idx <= `REG_PWM_LAST || idx == `REG_CTRL);
  assign rd_ok = aligned && (idx <= `REG_RES3 || idx == `REG_CTRL || idx == `REG_STAT ||
                             (idx >= `REG_ADC_FIRST && idx <= `REG_ADC_LAST));
  assign pready = clk_en;
  assign pslverr = psel && penable && (pwrite ? !wr_ok : !rd_ok);
  assign wr_acc = psel && penable && pwrite && pready && wr_ok;
  assign rd_acc = psel && penable && !pwrite && pready && rd_ok;
  assign prdata = {20'h0, r.rdata};

  // read mux; adc result words read zero since the converter sits outside
  always_comb begin
    case (idx)
      `REG_RES0: rd_mux = r.res0;
      4'h1: rd_mux = r.res1;
      4'h2: rd_mux = r.res2;
      `REG_RES3: rd_mux = r.res3;
      `REG_CTRL: rd_mux = r.ctrl;
      `REG_STAT: begin
        rd_mux = 12'h000;
        rd_mux[`STAT_ANY] = r.stat[2];
        rd_mux[`STAT_TR] = r.stat[1];
        rd_mux[`STAT_ADC] = r.stat[0];
      end
      default: rd_mux = 12'h000;
    endcase
  end

  // ****************************************
  // system clock divider
  // ****************************************
  // the engine and edge pulse advance on tick, every second edge when divided
  assign tick = !r.ctrl[`CTRL_CLKDIV] || r.tick_ph;

  // ****************************************
  // transform arithmetic
  // ****************************************
  // undo the half-turn folding made before the cordic ran
  assign cos_v = r.flip ? -$signed(r.cx) : $signed(r.cx);
  assign sin_v = r.flip ? -$signed(r.cy) : $signed(r.cy);

  // clarke stage; two-phase mode derives phase one from the others
  assign ix = r.ctrl[`CTRL_THREE] ? r.in1 :
              sat(mul(-(ext(r.in2) + ext(r.in3)), `FULL_ONE));
  assign iy = sat(mul(ext(r.in3) - ext(r.in2), `INV_SQRT3));

  // forward park stage
  assign vx = sat(mul(ext(r.in1), cos_v) - mul(ext(r.in2), sin_v));
  assign vy = sat(mul(ext(r.in1), sin_v) + mul(ext(r.in2), cos_v));

  // ****************************************
  // interrupt sources
  // ****************************************
  assign tr_done = (r.st == vt_pkg::ST_WAIT) && tick &&
                   (r.cnt == ((r.dir == vt_pkg::DIR_FWD) ? `FWD_CYCLES : `REV_CYCLES) - 6'h1);
  assign ev_adc = adc_eoc && r.ctrl[`CTRL_ADC_IE];
  assign ev_tr = tr_done && r.ctrl[`CTRL_TR_IE];

  // open drain: only ever drives low, released otherwise
  assign drive_low = r.ctrl[`CTRL_LEVEL] ? r.stat[2] : r.pulse;
  assign irq_n_out = 1'b0;
  assign irq_n_oe = !drive_low;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [3:0] i;
    logic signed [15:0] dx;
    logic signed [15:0] dy;
    logic [15:0] a16;
    logic [2:0] clr;
    i = r.cnt[3:0];
    dx = $signed(r.cx) >>> i;
    dy = $signed(r.cy) >>> i;
    a16 = {pwdata[11:0], 4'h0};
    clr = 3'h0;
    next_r = r;
    next_r.tick_ph = r.ctrl[`CTRL_CLKDIV] ? !r.tick_ph : 1'b0;

    // capture read data in the setup phase so it is stable in access
    if (psel && !penable && !pwrite) begin
      next_r.rdata = rd_mux;
    end

    // register writes take effect on the completing edge
    if (wr_acc) begin
      case (idx)
        `REG_IN1: next_r.in1 = pwdata[11:0];
        `REG_IN2: next_r.in2 = pwdata[11:0];
        `REG_IN3: next_r.in3 = pwdata[11:0];
        `REG_CTRL: next_r.ctrl = pwdata[11:0];
        default: next_r.ctrl = r.ctrl; // angles start below, pwm words dropped
      endcase
    end

    // engine sequence; counting runs on system ticks only
    case (r.st)
      vt_pkg::ST_IDLE: begin
        // a start while busy is ignored, one transform at a time
        if (wr_acc && (idx == `REG_REV_ANGLE || idx == `REG_FWD_ANGLE)) begin
          next_r.st = vt_pkg::ST_ROTATE;
          next_r.dir = (idx == `REG_FWD_ANGLE) ? vt_pkg::DIR_FWD : vt_pkg::DIR_REV;
          next_r.cnt = 6'h0;
          // fold angles beyond a quarter turn by a half turn
          next_r.flip = a16[15] ^ a16[14];
          next_r.cz = {a16[15] ^ (a16[15] ^ a16[14]), a16[15] ^ (a16[15] ^ a16[14]), a16[14:0]};
          next_r.cx = `INV_GAIN;
          next_r.cy = 16'h0000;
        end
      end
      vt_pkg::ST_ROTATE: begin
        // one cordic step per tick builds cosine and sine
        if (tick) begin
          next_r.cnt = r.cnt + 6'h1;
          if (!r.cz[16]) begin
            next_r.cx = r.cx - dy;
            next_r.cy = r.cy + dx;
            next_r.cz = $signed(r.cz) - atan(i);
          end else begin
            next_r.cx = r.cx + dy;
            next_r.cy = r.cy - dx;
            next_r.cz = $signed(r.cz) + atan(i);
          end
          if (i == `CORDIC_STEPS - 4'h1) begin
            next_r.st = vt_pkg::ST_COMPUTE;
          end
        end
      end
      vt_pkg::ST_COMPUTE: begin
        // results land well before completion is flagged
        if (tick) begin
          next_r.cnt = r.cnt + 6'h1;
          next_r.st = vt_pkg::ST_WAIT;
          if (r.dir == vt_pkg::DIR_REV) begin
            next_r.res0 = sat(mul(ext(ix), cos_v) + mul(ext(iy), sin_v));
            next_r.res1 = sat(mul(ext(iy), cos_v) - mul(ext(ix), sin_v));
            next_r.res2 = ix;
            next_r.res3 = iy;
          end else begin
            next_r.res0 = vx;
            next_r.res1 = sat(-mul(ext(vx), `HALF_ONE) - mul(ext(vy), `HALF_SQRT3));
            next_r.res2 = sat(-mul(ext(vx), `HALF_ONE) + mul(ext(vy), `HALF_SQRT3));
            next_r.res3 = vy;
          end
        end
      end
      vt_pkg::ST_WAIT: begin
        // pad out to the fixed completion time of each direction
        if (tick) begin
          next_r.cnt = r.cnt + 6'h1;
          if (tr_done) begin
            next_r.st = vt_pkg::ST_IDLE;
          end
        end
      end
      default: next_r.st = vt_pkg::ST_IDLE;
    endcase

    // status read clears exactly the bits it put on the bus
    if (rd_acc && idx == `REG_STAT) begin
      clr = {r.rdata[`STAT_ANY], r.rdata[`STAT_TR], r.rdata[`STAT_ADC]};
    end
    // a new event in the clearing cycle wins over the clear
    next_r.stat = (r.stat & ~clr) | {ev_adc || ev_tr, ev_tr, ev_adc};

    // edge mode pulse lasts until the next system tick
    if (ev_adc || ev_tr) begin
      next_r.pulse = 1'b1;
    end else if (tick) begin
      next_r.pulse = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // reset clears control, so interrupts are off, edge and two-phase modes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

endmodule : vector_transform_with_interrupts
`default_nettype wire

/* File: tb/vt_checker.sv */
// checker: port relations of the vector transform engine.
// assumes one clock domain; bound to the engine at the foot.
`timescale 1ns/1ps
`default_nettype none
module vt_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_eoc,
  input wire logic irq_n_in,
  input wire logic irq_n_out,
  input wire logic irq_n_oe
);
  logic [11:0] sh; // shadow of the control word
  logic stat_rd; // status read access phase
  assign stat_rd = psel && penable && !pwrite && paddr == 6'h38;
  // shadow follows accepted control writes only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sh <= 12'h000;
    end else if (psel && penable && pwrite && clk_en && paddr == 6'h34) begin
      sh <= pwdata[11:0];
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // starts with transform interrupts on and the divider off; busy starts are not used
  sequence rev_go;
    psel && penable && pwrite && pready && paddr == 6'h00 && sh[6] && !sh[5];
  endsequence
  sequence fwd_go;
    psel && penable && pwrite && pready && paddr == 6'h10 && sh[6] && !sh[5];
  endsequence
  a_rev_done_time: assert property (rev_go |-> ##37 irq_n_oe ##1 !irq_n_oe)
    else $error("reverse completion not 37 cycles after start");
  a_fwd_done_time: assert property (fwd_go |-> ##40 irq_n_oe ##1 !irq_n_oe)
    else $error("forward completion not 40 cycles after start");
  a_edge_one_cycle: assert property (!sh[8] && !sh[5] && $fell(irq_n_oe) |=> irq_n_oe)
    else $error("edge mode request longer than one cycle");
  a_edge_div_len: assert property (!sh[8] && sh[5] && $fell(irq_n_oe) |-> ##2 irq_n_oe)
    else $error("divided edge mode request longer than one system period");
  a_level_holds: assert property (sh[8] && !irq_n_oe && !stat_rd |=> !irq_n_oe)
    else $error("level request released without status read");
  a_read_releases: assert property (sh[8] && stat_rd && !adc_eoc |=> irq_n_oe)
    else $error("status read did not release level request");
  a_adc_request: assert property (sh[7] && !sh[8] && adc_eoc |=> !irq_n_oe)
    else $error("enabled adc event gave no request");
  a_quiet_disabled: assert property (sh[7:6] == 2'b00 && irq_n_oe |=> irq_n_oe)
    else $error("request with all sources disabled");
  a_drain_only: assert property (irq_n_out == 1'b0)
    else $error("request pin data not low");
  a_data_twelve: assert property (prdata[31:12] == 20'h00000)
    else $error("read data above bit 11 not zero");
  a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
endmodule : vt_checker
bind vector_transform_with_interrupts vt_checker u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_eoc(adc_eoc),
  .irq_n_in(irq_n_in), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
`default_nettype wire

/* File: tb/vt_board.sv */
// board model: pulled-up request wire and an adc end-of-conversion source.
// assumes fire is a one-cycle request from the bench on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module vt_board (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fire,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  output logic adc_eoc,
  output wire logic irq_wire
);
  // released pin floats up through the resistor, never to a stale value
  assign irq_wire = irq_n_oe ? 1'b1 : irq_n_out;
  // conversion end is a registered one-cycle pulse
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      adc_eoc <= 1'b0;
    end else begin
      adc_eoc <= fire;
    end
  end
endmodule : vt_board
`default_nettype wire

/* File: tb/vector_transform_with_interrupts_tb.sv */
// self-checking bench for the vector transform engine.
// assumes the engine, its checker and the board model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module vector_transform_with_interrupts_tb;
  logic ref_clk = 0, nrst = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, adc_eoc, irq_n_out, irq_n_oe;
  wire logic irq_wire; // resolved request wire
  logic [11:0] rd; // last read word
  logic er; // last error answer
  int err_count = 0, cmp_count = 0;
  vector_transform_with_interrupts dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_eoc(adc_eoc),
    .irq_n_in(irq_wire), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  vt_board board (.ref_clk(ref_clk), .nrst(nrst), .fire(fire), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .adc_eoc(adc_eoc), .irq_wire(irq_wire));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string w, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  // cordic results may sit a few lsb off the exact value
  task automatic near(input string w, input logic [11:0] e);
    logic signed [12:0] df;
    df = $signed({rd[11], rd}) - $signed({e[11], e});
    check(w, (df <= 3 && df >= -3) ? e : rd, e);
  endtask : near
  // one apb transfer; an idle edge first keeps drives one per time step
  task automatic apb(input logic w, input logic [5:0] a, input logic [11:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {20'h00000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[11:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_count++;
      end_of_test();
    end
  endtask : apb
  // counts cycles from the edge it is called on until the wire falls
  task automatic wait_irq(input int exp);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (irq_wire !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_count++;
      end_of_test();
    end else begin
      check("request delay", n[11:0], exp[11:0]);
    end
  endtask : wait_irq
  task automatic t_reset();
    apb(0, 6'h34, 0);
    check("control reset", rd, 12'h000);
    apb(0, 6'h38, 0);
    check("status reset", rd, 12'h000);
    apb(0, 6'h3c, 0);
    check("reserved read", {11'h0, er}, 12'h001);
    apb(1, 6'h2c, 12'h005);
    check("reserved write", {11'h0, er}, 12'h001);
    apb(1, 6'h35, 0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_rev();
    apb(1, 6'h34, 12'h040);
    apb(1, 6'h08, 12'hf00);
    apb(1, 6'h0c, 12'h200);
    apb(1, 6'h00, 12'h400); // quarter turn
    wait_irq(37);
    @(posedge ref_clk);
    #1;
    check("edge pulse end", {11'h0, irq_wire}, 12'h001);
    apb(0, 6'h08, 0);
    check("alpha current", rd, 12'hf00);
    apb(0, 6'h0c, 0);
    near("beta current", 12'h1bb);
    apb(0, 6'h00, 0);
    near("direct current", 12'h1bb);
    apb(0, 6'h04, 0);
    near("quadrature current", 12'h100);
    apb(0, 6'h38, 0);
    check("status transform", rd, 12'h802);
    apb(0, 6'h38, 0);
    check("status cleared", rd, 12'h000);
    $display("test reverse done");
  endtask : t_rev
  task automatic t_fwd();
    apb(1, 6'h34, 12'h540);
    apb(1, 6'h04, 12'h200);
    apb(1, 6'h08, 12'h100);
    apb(1, 6'h10, 12'h400);
    wait_irq(40);
    repeat (8) @(posedge ref_clk);
    #1;
    check("level held", {11'h0, irq_wire}, 12'h000);
    apb(0, 6'h00, 0);
    near("phase one voltage", 12'hf00);
    apb(0, 6'h04, 0);
    near("phase two voltage", 12'hec5);
    apb(0, 6'h08, 0);
    near("phase three voltage", 12'h23b);
    apb(0, 6'h0c, 0);
    near("beta voltage", 12'h200);
    apb(0, 6'h38, 0);
    #1;
    check("status forward", rd, 12'h802);
    check("level released", {11'h0, irq_wire}, 12'h001);
    $display("test forward done");
  endtask : t_fwd
  task automatic t_adc();
    int i;
    // enabled then disabled adc source, same pulse each time
    for (i = 0; i < 2; i++) begin
      apb(1, 6'h34, i == 0 ? 12'h080 : 12'h000);
      @(posedge ref_clk);
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      if (i == 0) begin
        wait_irq(1);
      end
      apb(0, 6'h38, 0);
      check("status adc", rd, i == 0 ? 12'h801 : 12'h000);
    end
    $display("test adc done");
  endtask : t_adc
  // divided system clock: start lands three edges after the control write,
  // so the 37th tick falls 73 edges later and the pulse spans two edges
  task automatic t_div();
    apb(1, 6'h34, 12'h060);
    apb(1, 6'h00, 12'h400);
    wait_irq(73);
    @(posedge ref_clk);
    #1;
    check("divided pulse held", {11'h0, irq_wire}, 12'h000);
    @(posedge ref_clk);
    #1;
    check("divided pulse end", {11'h0, irq_wire}, 12'h001);
    $display("test divider done");
  endtask : t_div
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_rev();
    t_fwd();
    t_adc();
    t_div();
    end_of_test();
  end
endmodule : vector_transform_with_interrupts_tb
`default_nettype wire
